// ---- fns_cfg.svh ----
`ifndef FNS_CFG_SVH
`define FNS_CFG_SVH

// Register byte offsets
`define FNS_OFF_CW0 8'h00
`define FNS_OFF_CW1 8'h04
`define FNS_OFF_CW2 8'h08
`define FNS_OFF_STAT 8'h0C

// Control word zero fields
`define FNS_FRAC_LSB 4
`define FNS_INT_LSB 18
`define FNS_SYNTH_EN_BIT 28
`define FNS_MUX_LSB 29

// Control word one fields
`define FNS_RDIV_LSB 4
`define FNS_CKDIV_LSB 8
`define FNS_OSC_EN_BIT 12
`define FNS_LOWBAND_BIT 13
`define FNS_VBIAS_LSB 16
`define FNS_VADJ_LSB 20

// Control word two fields
`define FNS_PA_EN_BIT 4
`define FNS_MOD_LSB 6
`define FNS_PWR_LSB 9
`define FNS_MODNUM_LSB 15
`define FNS_PABIAS_LSB 30

// Status word fields
`define FNS_ST_CE_BIT 0
`define FNS_ST_RDY_BIT 1
`define FNS_ST_LOCK_BIT 2
`define FNS_ST_FB_LSB 4

// Reset values
`define FNS_CW0_RST 32'h0000_0000
`define FNS_CW1_RST 32'h0000_1410
`define FNS_CW2_RST 32'h0000_0000

// Codes and limits
`define FNS_MOD_FSK 3'h0
`define FNS_MIN_INT 8'h1F
`define FNS_LOCK_RUNS 3'h5

// Timing
`define FNS_CLK_MHZ 250
`define FNS_LOCK_NS 15
`define FNS_UNLOCK_NS 25
`define FNS_LOCK_CYC (((`FNS_LOCK_NS*`FNS_CLK_MHZ)+999)/1000)
`define FNS_UNLOCK_CYC (((`FNS_UNLOCK_NS*`FNS_CLK_MHZ)+999)/1000)

`endif

// ---- fns_pin_model.sv ----
module fns_pin_model
(
    input wire logic pclk,
    input wire logic chip_enable_pin,
    input wire logic phase_detector_tick,
    input wire logic [3:0] pulse_width,
    output logic reg_ready_pin,
    output logic pd_up_pin,
    output logic pd_down_pin
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] wait_cnt = 4'h0;
    logic [3:0] pulse_cnt = 4'h0;
    logic use_down = 1'b0;

    // Regulator settles after chip enable, drops at once
    always_ff @(posedge pclk)
    begin
        if (!chip_enable_pin)
            wait_cnt <= 4'h0;
        else if (wait_cnt != 4'hF)
            wait_cnt <= wait_cnt + 4'h1;
    end

    assign reg_ready_pin = chip_enable_pin && (wait_cnt >= 4'h8);

    // One pump pulse per tick, up and down in turn
    always_ff @(posedge pclk)
    begin
        if (phase_detector_tick)
        begin
            pulse_cnt <= pulse_width;
            use_down <= !use_down;
        end
        else if (pulse_cnt != 4'h0)
            pulse_cnt <= pulse_cnt - 4'h1;
    end

    assign pd_up_pin = (pulse_cnt != 4'h0) && !use_down;
    assign pd_down_pin = (pulse_cnt != 4'h0) && use_down;
endmodule

// ---- fns_pkg.sv ----
package fns_pkg;

    typedef enum logic [2:0]
    {
        FNS_MUX_REG_READY,
        FNS_MUX_LOCK,
        FNS_MUX_PD_TICK,
        FNS_MUX_FB_CARRY,
        FNS_MUX_TX_BIT,
        FNS_MUX_LOW,
        FNS_MUX_HIGH,
        FNS_MUX_CE
    } fns_mux_t;

    typedef enum logic
    {
        FNS_UNLOCKED,
        FNS_LOCKED
    } fns_lock_t;

endpackage

// ---- fns_synth_ctrl.sv ----
// Summary of operation
// - Oscillator enable bit drives oscillator; on at reset; off while chip enable low.
// - Divided clock output is reference over even ratio 2..30, 50:50, default 8.
// - Divided clock ratio zero stops driving the divided clock output.
// - Three-bit reference counter divides by 1..7, default 1, forms detector tick.
// - Status output source picked by bits 31:29 of control word zero.
// - Status output shows regulator ready after reset.
// - Lock flag active high, set after five comparison periods in a row with error below 15 ns.
// - Lock flag stays set until a 25 ns error or synthesizer disable, then clears.
// - Chip enable low disables regulators and clears all configuration.
// - Feedback divider is 8-bit integer plus 14-bit fraction, integer at least 31.
// - Output frequency is reference over R times integer plus fraction/2^15.
// - VCO adjust field bits 21:20 of word one re-centres the oscillator.
// - Bit 28 of word zero enables synthesizer loop and VCO together.
// - Low-band bit adds divide-by-two; host doubles the divider value.
// - Amplifier power from bits 14:9 of word two, independent of transmit bit.
// - Bits 31:30 of word two set amplifier bias; bit 4 clear powers down.
// - FSK offsets divider by transmit bit, deviation detector rate times M/2^14.
// - Modulation scheme chosen by bits 8:6 of word two.
//
// Added by the designer: the address map and the APB interface to the registers.
`include "fns_cfg.svh"

module fns_synth_ctrl
#(
    parameter int ADDR_W = 8
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic chip_enable_pin,
    input wire logic reg_ready_pin,
    input wire logic pd_up_pin,
    input wire logic pd_down_pin,
    input wire logic transmit_bit_input,
    output logic regulator_enable,
    output logic osc_enable,
    output logic divided_ref_clock_output,
    output logic divided_ref_clock_oe,
    output logic phase_detector_tick,
    output logic status_select_output,
    output logic lock_detect,
    output logic synth_enable,
    output logic vco_enable,
    output logic [1:0] vco_adjust,
    output logic [3:0] vco_bias,
    output logic low_band_div2,
    output logic [8:0] fb_div_int,
    output logic pa_enable,
    output logic [5:0] pa_power,
    output logic [1:0] pa_bias,
    output logic [2:0] mod_scheme
);

    function automatic logic [2:0] fns_nonzero(input logic [2:0] v);
        fns_nonzero = (v == 3'h0) ? 3'h1 : v;
    endfunction

    // Two-flop synchronisers for pins
    logic [4:0] sync_a;
    logic [4:0] sync_b;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync_a <= 5'h00;
            sync_b <= 5'h00;
        end
        else if (clk_en)
        begin
            sync_a <= {transmit_bit_input, pd_down_pin, pd_up_pin,
                       reg_ready_pin, chip_enable_pin};
            sync_b <= sync_a;
        end
    end

    wire logic ce_s = sync_b[0];
    wire logic rdy_s = sync_b[1];
    wire logic err_s = sync_b[2] | sync_b[3];
    wire logic tx_s = sync_b[4];

    // Configuration words
    logic [31:0] cw0;
    logic [31:0] cw1;
    logic [31:0] cw2;

    // APB decode
    wire logic hit_cw0 = (paddr == ADDR_W'(`FNS_OFF_CW0));
    wire logic hit_cw1 = (paddr == ADDR_W'(`FNS_OFF_CW1));
    wire logic hit_cw2 = (paddr == ADDR_W'(`FNS_OFF_CW2));
    wire logic hit_st = (paddr == ADDR_W'(`FNS_OFF_STAT));
    wire logic hit_any = hit_cw0 | hit_cw1 | hit_cw2 | hit_st;
    wire logic access = psel & penable;
    wire logic setup = psel & ~penable;
    wire logic wr_ok = access & pwrite & hit_any & ce_s;

    assign pready = 1'b1;
    assign pslverr = access & ~hit_any;

    // Field views
    wire logic [13:0] f_frac = cw0[`FNS_FRAC_LSB +: 14];
    wire logic [7:0] f_int = cw0[`FNS_INT_LSB +: 8];
    wire logic f_synth = cw0[`FNS_SYNTH_EN_BIT];
    wire fns_pkg::fns_mux_t f_mux = fns_pkg::fns_mux_t'(cw0[`FNS_MUX_LSB +: 3]);
    wire logic [2:0] f_rdiv = cw1[`FNS_RDIV_LSB +: 3];
    wire logic [3:0] f_ckdiv = cw1[`FNS_CKDIV_LSB +: 4];
    wire logic f_osc = cw1[`FNS_OSC_EN_BIT];
    wire logic [8:0] f_modnum = cw2[`FNS_MODNUM_LSB +: 9];
    wire logic f_fsk = (cw2[`FNS_MOD_LSB +: 3] == `FNS_MOD_FSK);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cw0 <= `FNS_CW0_RST;
            cw1 <= `FNS_CW1_RST;
            cw2 <= `FNS_CW2_RST;
        end
        else if (clk_en)
        begin
            if (!ce_s)
            begin
                cw0 <= `FNS_CW0_RST;
                cw1 <= `FNS_CW1_RST;
                cw2 <= `FNS_CW2_RST;
            end
            else if (wr_ok)
            begin
                if (hit_cw0)
                    cw0 <= pwdata;
                if (hit_cw1)
                    cw1 <= pwdata;
                if (hit_cw2)
                    cw2 <= pwdata;
            end
        end
    end

    // Read data captured in setup phase
    logic [31:0] next_prdata;
    always_comb
    begin
        next_prdata = 32'h0000_0000;
        if (hit_cw0)
            next_prdata = cw0;
        if (hit_cw1)
            next_prdata = cw1;
        if (hit_cw2)
            next_prdata = cw2;
        if (hit_st)
        begin
            next_prdata[`FNS_ST_CE_BIT] = ce_s;
            next_prdata[`FNS_ST_RDY_BIT] = rdy_s;
            next_prdata[`FNS_ST_LOCK_BIT] = lock_detect;
            next_prdata[`FNS_ST_FB_LSB +: 9] = fb_div_int;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (clk_en && setup)
            prdata <= next_prdata;
    end

    // Divided reference clock, half period of n cycles
    logic [3:0] ck_cnt;
    wire logic ck_wrap = (ck_cnt >= f_ckdiv - 4'h1);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ck_cnt <= 4'h0;
            divided_ref_clock_output <= 1'b0;
            divided_ref_clock_oe <= 1'b0;
        end
        else if (clk_en)
        begin
            divided_ref_clock_oe <= (f_ckdiv != 4'h0);
            if (f_ckdiv == 4'h0)
            begin
                ck_cnt <= 4'h0;
                divided_ref_clock_output <= 1'b0;
            end
            else if (ck_wrap)
            begin
                ck_cnt <= 4'h0;
                divided_ref_clock_output <= ~divided_ref_clock_output;
            end
            else
                ck_cnt <= ck_cnt + 4'h1;
        end
    end

    // Reference counter
    logic [2:0] r_cnt;
    wire logic [2:0] r_eff = fns_nonzero(f_rdiv);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r_cnt <= 3'h0;
            phase_detector_tick <= 1'b0;
        end
        else if (clk_en)
        begin
            if (r_cnt >= r_eff - 3'h1)
            begin
                r_cnt <= 3'h0;
                phase_detector_tick <= 1'b1;
            end
            else
            begin
                r_cnt <= r_cnt + 3'h1;
                phase_detector_tick <= 1'b0;
            end
        end
    end

    // Phase error width per comparison period
    logic [3:0] err_cnt;
    wire logic good_err = (err_cnt < 4'(`FNS_LOCK_CYC));
    wire logic bad_err = (err_cnt >= 4'(`FNS_UNLOCK_CYC));
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            err_cnt <= 4'h0;
        else if (clk_en)
        begin
            if (phase_detector_tick)
                err_cnt <= {3'h0, err_s};
            else if (err_s && err_cnt != 4'hF)
                err_cnt <= err_cnt + 4'h1;
        end
    end

    // Lock detect
    fns_pkg::fns_lock_t lk_state;
    logic [2:0] run_cnt;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lk_state <= fns_pkg::FNS_UNLOCKED;
            run_cnt <= 3'h0;
        end
        else if (clk_en)
        begin
            if (!synth_enable)
            begin
                lk_state <= fns_pkg::FNS_UNLOCKED;
                run_cnt <= 3'h0;
            end
            else if (phase_detector_tick)
            begin
                unique case (lk_state)
                    fns_pkg::FNS_UNLOCKED:
                    begin
                        if (!good_err)
                            run_cnt <= 3'h0;
                        else if (run_cnt == `FNS_LOCK_RUNS - 3'h1)
                        begin
                            run_cnt <= 3'h0;
                            lk_state <= fns_pkg::FNS_LOCKED;
                        end
                        else
                            run_cnt <= run_cnt + 3'h1;
                    end
                    fns_pkg::FNS_LOCKED:
                    begin
                        if (bad_err)
                            lk_state <= fns_pkg::FNS_UNLOCKED;
                    end
                endcase
            end
        end
    end
    assign lock_detect = (lk_state == fns_pkg::FNS_LOCKED);

    // Feedback divider with first-order sigma-delta and FSK offset
    wire logic [7:0] int_eff = (f_int < `FNS_MIN_INT) ? `FNS_MIN_INT : f_int;
    wire logic [24:0] fb_base = {2'h0, int_eff, 15'h0000}
                              + {11'h000, f_frac};
    wire logic [24:0] fb_dev = {15'h0000, f_modnum, 1'b0};
    wire logic [24:0] fb_word = !f_fsk ? fb_base
                              : (tx_s ? fb_base + fb_dev : fb_base - fb_dev);
    logic [14:0] sd_acc;
    wire logic [15:0] sd_sum = {1'b0, sd_acc} + {1'b0, fb_word[14:0]};
    logic fb_carry;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sd_acc <= 15'h0000;
            fb_carry <= 1'b0;
            fb_div_int <= 9'h01F;
        end
        else if (clk_en && phase_detector_tick)
        begin
            sd_acc <= sd_sum[14:0];
            fb_carry <= sd_sum[15];
            fb_div_int <= fb_word[23:15] + {8'h00, sd_sum[15]};
        end
    end

    // Status select
    logic next_status;
    always_comb
    begin
        unique case (f_mux)
            fns_pkg::FNS_MUX_REG_READY: next_status = rdy_s;
            fns_pkg::FNS_MUX_LOCK: next_status = lock_detect;
            fns_pkg::FNS_MUX_PD_TICK: next_status = phase_detector_tick;
            fns_pkg::FNS_MUX_FB_CARRY: next_status = fb_carry;
            fns_pkg::FNS_MUX_TX_BIT: next_status = tx_s;
            fns_pkg::FNS_MUX_LOW: next_status = 1'b0;
            fns_pkg::FNS_MUX_HIGH: next_status = 1'b1;
            fns_pkg::FNS_MUX_CE: next_status = ce_s;
        endcase
    end

    // Registered analog controls
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            status_select_output <= 1'b0;
            regulator_enable <= 1'b0;
            osc_enable <= 1'b0;
            synth_enable <= 1'b0;
            vco_enable <= 1'b0;
            vco_adjust <= 2'h0;
            vco_bias <= 4'h0;
            low_band_div2 <= 1'b0;
            pa_enable <= 1'b0;
            pa_power <= 6'h00;
            pa_bias <= 2'h0;
            mod_scheme <= 3'h0;
        end
        else if (clk_en)
        begin
            status_select_output <= next_status;
            regulator_enable <= ce_s;
            osc_enable <= f_osc & ce_s;
            synth_enable <= f_synth & ce_s;
            vco_enable <= f_synth & ce_s;
            vco_adjust <= cw1[`FNS_VADJ_LSB +: 2];
            vco_bias <= cw1[`FNS_VBIAS_LSB +: 4];
            low_band_div2 <= cw1[`FNS_LOWBAND_BIT];
            pa_enable <= cw2[`FNS_PA_EN_BIT] & ce_s;
            pa_power <= cw2[`FNS_PWR_LSB +: 6];
            pa_bias <= cw2[`FNS_PABIAS_LSB +: 2];
            mod_scheme <= cw2[`FNS_MOD_LSB +: 3];
        end
    end

    // Checking helpers
    logic [3:0] ck_seen;
    logic ck_stable;
    logic [2:0] good_seq;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ck_seen <= 4'h0;
            ck_stable <= 1'b0;
            good_seq <= 3'h0;
        end
        else if (clk_en)
        begin
            ck_stable <= (f_ckdiv != 4'h0) && (ck_stable || ck_seen == 4'h0);
            if (ck_wrap || f_ckdiv == 4'h0)
                ck_seen <= 4'h0;
            else
                ck_seen <= ck_seen + 4'h1;
            if (!synth_enable || (phase_detector_tick && !good_err))
                good_seq <= 3'h0;
            else if (phase_detector_tick && good_seq != 3'h7)
                good_seq <= good_seq + 3'h1;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn || !clk_en);

    sequence s_good_tick;
        phase_detector_tick && good_err && synth_enable;
    endsequence
    sequence s_bad_tick;
        phase_detector_tick && bad_err;
    endsequence

    property p_osc_off;
        !ce_s |=> !osc_enable && !regulator_enable;
    endproperty
    a_osc_off: assert property (p_osc_off) else $error("osc on");

    property p_ck_half;
        ck_wrap && ck_stable && $stable(f_ckdiv) |->
            ck_seen == f_ckdiv - 4'h1;
    endproperty
    a_ck_half: assert property (p_ck_half) else $error("clk half");

    property p_ck_stop;
        f_ckdiv == 4'h0 ##1 f_ckdiv == 4'h0 |->
            !divided_ref_clock_oe && !divided_ref_clock_output;
    endproperty
    a_ck_stop: assert property (p_ck_stop) else $error("clk on");

    property p_lock_set;
        (!lock_detect && good_seq == 3'h4) and s_good_tick |=> lock_detect;
    endproperty
    a_lock_set: assert property (p_lock_set) else $error("no lock");

    property p_lock_early;
        $rose(lock_detect) |-> $past(good_seq) == 3'h4;
    endproperty
    a_lock_early: assert property (p_lock_early) else $error("early");

    property p_unlock;
        lock_detect and s_bad_tick |=> !lock_detect;
    endproperty
    a_unlock: assert property (p_unlock) else $error("kept lock");

    property p_lock_hold;
        lock_detect && synth_enable && !bad_err |=> lock_detect;
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("lost");

    property p_ce_clear;
        !ce_s |=> cw0 == `FNS_CW0_RST && cw1 == `FNS_CW1_RST
                  && cw2 == `FNS_CW2_RST;
    endproperty
    a_ce_clear: assert property (p_ce_clear) else $error("cfg kept");

    property p_int_min;
        phase_detector_tick |=> fb_div_int >= 9'h01F;
    endproperty
    a_int_min: assert property (p_int_min) else $error("n small");

    property p_mux_rdy;
        f_mux == fns_pkg::FNS_MUX_REG_READY |=>
            status_select_output == $past(rdy_s);
    endproperty
    a_mux_rdy: assert property (p_mux_rdy) else $error("mux");

    property p_pwr_tx;
        $changed(tx_s) && $stable(cw2) |=> $stable(pa_power);
    endproperty
    a_pwr_tx: assert property (p_pwr_tx) else $error("pwr tx");

    property p_pa_off;
        !cw2[`FNS_PA_EN_BIT] |=> !pa_enable;
    endproperty
    a_pa_off: assert property (p_pa_off) else $error("pa on");

endmodule

// ---- tb_fns_synth_ctrl.sv ----
module tb_fns_synth_ctrl;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {logic [7:0] a; logic [31:0] d; logic e;} fns_row_t;
    typedef struct
    {
        logic [7:0] n;
        logic [13:0] f;
        logic [8:0] m;
        logic tx;
        logic [2:0] md;
        logic [15:0] sum;
    } fns_fb_t;

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic chip_enable_pin = 1'b0;
    logic transmit_bit_input = 1'b0;
    logic [3:0] pulse_width = 4'h0;
    logic [31:0] prdata;
    logic pready, pslverr, reg_ready_pin, pd_up_pin, pd_down_pin;
    logic regulator_enable, osc_enable, divided_ref_clock_output;
    logic divided_ref_clock_oe, phase_detector_tick, status_select_output;
    logic lock_detect, synth_enable, vco_enable, low_band_div2, pa_enable;
    logic [1:0] vco_adjust, pa_bias;
    logic [3:0] vco_bias;
    logic [8:0] fb_div_int;
    logic [5:0] pa_power;
    logic [2:0] mod_scheme;
    logic [31:0] rd, sum;
    logic [31:0] s [3];
    logic er;
    int errors = 0;
    int compares = 0;
    int h, l;
    int ckn [4] = '{4, 1, 15, 0};
    int rv [3] = '{1, 3, 7};
    logic [7:0] mux_exp = 8'hD5;
    fns_row_t rows [6] = '{
        '{8'h00, 32'h1000_0000, 1'b0},
        '{8'h04, 32'h003C_3310, 1'b0},
        '{8'h08, 32'h4000_7E10, 1'b0},
        '{8'h08, 32'h8123_45C0, 1'b0},
        '{8'h10, 32'hFFFF_FFFF, 1'b1},
        '{8'h05, 32'h1234_5678, 1'b1}
    };
    fns_fb_t fb [7] = '{
        '{8'h28, 14'h0000, 9'h000, 1'b0, 3'h0, 16'h0A00},
        '{8'h14, 14'h0000, 9'h000, 1'b0, 3'h0, 16'h07C0},
        '{8'h28, 14'h2000, 9'h000, 1'b0, 3'h0, 16'h0A10},
        '{8'h28, 14'h0000, 9'h100, 1'b1, 3'h0, 16'h0A01},
        '{8'h28, 14'h0000, 9'h100, 1'b0, 3'h0, 16'h09FF},
        '{8'h28, 14'h0000, 9'h100, 1'b0, 3'h1, 16'h0A00},
        '{8'hFF, 14'h0000, 9'h000, 1'b0, 3'h0, 16'h3FC0}
    };

    initial
    begin
        forever #2 pclk = ~pclk;
    end

    fns_synth_ctrl fns_synth_ctrl_inst
    (
        .pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .chip_enable_pin, .reg_ready_pin,
        .pd_up_pin, .pd_down_pin, .transmit_bit_input, .regulator_enable,
        .osc_enable, .divided_ref_clock_output, .divided_ref_clock_oe,
        .phase_detector_tick, .status_select_output, .lock_detect,
        .synth_enable, .vco_enable, .vco_adjust, .vco_bias, .low_band_div2,
        .fb_div_int, .pa_enable, .pa_power, .pa_bias, .mod_scheme
    );

    fns_pin_model fns_pin_model_inst
    (
        .pclk, .chip_enable_pin, .phase_detector_tick, .pulse_width,
        .reg_ready_pin, .pd_up_pin, .pd_down_pin
    );

    task automatic give_verdict();
        $display("Comparisons %0d, errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic fail(input string m);
        errors++;
        $display("CHECK FAILED at %0t: %s", $time, m);
    endtask

    task automatic abort_run();
        fail("timeout");
        give_verdict();
    endtask

    task automatic chk_w(input logic [31:0] g, e, input string m);
        compares++;
        if (g !== e)
            fail(m);
    endtask

    task automatic chk_b(input logic g, e, input string m);
        compares++;
        if (g !== e)
            fail(m);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    // APB transfer: setup, then access until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 16)
            abort_run();
    endtask

    function automatic logic cur(input logic which);
        return which ? phase_detector_tick : divided_ref_clock_output;
    endfunction

    task automatic wait_sig(input logic which, v);
        int i;
        for (i = 0; i < 100 && cur(which) !== v; i++)
            cyc(1);
        if (i == 100)
            abort_run();
    endtask

    task automatic run_len(input logic which, v, output int n);
        n = 0;
        while (n < 40 && cur(which) === v)
        begin
            n++;
            cyc(1);
        end
    endtask

    task automatic wait_ticks(input int k);
        for (int i = 0; i < 200 && k > 0; i++)
        begin
            cyc(1);
            if (phase_detector_tick === 1'b1)
                k--;
        end
        if (k > 0)
            abort_run();
    endtask

    task automatic wait_ready();
        int i;
        for (i = 0; i < 50; i++)
        begin
            apb(1'b0, 8'h0C, 32'h0000_0000);
            if (rd[1] === 1'b1)
                break;
        end
        if (i == 50)
            abort_run();
    endtask

    task automatic check_fields();
        chk_w({10'h000, synth_enable, vco_enable, vco_adjust, vco_bias,
            low_band_div2, osc_enable, pa_enable, pa_power, pa_bias,
            mod_scheme}, {10'h000, s[0][28], s[0][28], s[1][21:20],
            s[1][19:16], s[1][13], s[1][12], s[2][4], s[2][14:9],
            s[2][31:30], s[2][8:6]}, "fields");
    endtask

    initial
    begin
        repeat (5) @(posedge pclk);
        #1;
        chk_w({osc_enable, synth_enable, pa_enable, lock_detect}, 0, "rst");
        chk_w(fb_div_int, 32'h0000_001F, "rst fb");
        @(posedge pclk) presetn <= 1'b1;
        @(posedge pclk) chip_enable_pin <= 1'b1;
        cyc(3);
        wait_ready();
        cyc(2);
        chk_b(osc_enable, 1'b1, "osc on");
        chk_b(status_select_output, 1'b1, "mux ready");
        apb(1'b0, 8'h04, 32'h0000_0000);
        chk_w(rd, 32'h0000_1410, "word1 rst");
        // Divided clock, reset ratio first
        foreach (ckn[i])
        begin
            if (i > 0)
                apb(1'b1, 8'h04, 32'h0000_1010 | (ckn[i] << 8));
            cyc(3);
            if (ckn[i] == 0)
            begin
                chk_b(divided_ref_clock_oe, 1'b0, "ck oe");
                chk_b(divided_ref_clock_output, 1'b0, "ck out");
            end
            else
            begin
                chk_b(divided_ref_clock_oe, 1'b1, "ck oe on");
                wait_sig(1'b0, 1'b0);
                wait_sig(1'b0, 1'b1);
                run_len(1'b0, 1'b1, h);
                run_len(1'b0, 1'b0, l);
                chk_w(h, ckn[i], "ck high");
                chk_w(l, ckn[i], "ck low");
            end
        end
        // Detector tick spacing
        foreach (rv[i])
        begin
            apb(1'b1, 8'h04, 32'h0000_1400 | (rv[i] << 4));
            cyc(10);
            wait_sig(1'b1, 1'b1);
            run_len(1'b1, 1'b1, h);
            run_len(1'b1, 1'b0, l);
            chk_w(rv[i] == 1 ? h : h + l, rv[i] == 1 ? 40 : rv[i], "tick");
        end
        // Lock detect with tick every 7 cycles
        apb(1'b1, 8'h00, 32'h1000_0000);
        @(posedge pclk) pulse_width <= 4'h7;
        wait_ticks(3);
        chk_b(lock_detect, 1'b0, "lock bad");
        @(posedge pclk) pulse_width <= 4'h3;
        wait_ticks(4);
        chk_b(lock_detect, 1'b0, "lock early");
        @(posedge pclk) pulse_width <= 4'h5;
        wait_ticks(2);
        @(posedge pclk) pulse_width <= 4'h3;
        wait_ticks(4);
        chk_b(lock_detect, 1'b0, "run restart");
        wait_ticks(3);
        cyc(3);
        chk_b(lock_detect, 1'b1, "lock set");
        @(posedge pclk) pulse_width <= 4'h5;
        wait_ticks(4);
        chk_b(lock_detect, 1'b1, "lock hold");
        @(posedge pclk) pulse_width <= 4'h7;
        wait_ticks(3);
        cyc(3);
        chk_b(lock_detect, 1'b0, "lock clear");
        // Status select codes, tick always high
        @(posedge pclk) transmit_bit_input <= 1'b1;
        apb(1'b1, 8'h04, 32'h0000_1410);
        for (int c = 0; c < 8; c++)
        begin
            apb(1'b1, 8'h00, c << 29);
            cyc(5);
            chk_b(status_select_output, mux_exp[c], "mux");
        end
        // Register field rows
        s = '{32'hE000_0000, 32'h0000_1410, 32'h0000_0000};
        foreach (rows[i])
        begin
            apb(1'b1, rows[i].a, rows[i].d);
            chk_b(er, rows[i].e, "wr err");
            if (!rows[i].e)
                s[rows[i].a[3:2]] = rows[i].d;
            apb(1'b0, rows[i].a, 32'h0000_0000);
            chk_w(rd, rows[i].e ? 32'h0000_0000 : rows[i].d, "rd");
            chk_b(er, rows[i].e, "rd err");
            cyc(2);
            check_fields();
        end
        @(posedge pclk) transmit_bit_input <= 1'b0;
        cyc(4);
        check_fields();
        // Feedback divider rows, 64 ticks each
        apb(1'b1, 8'h04, 32'h0000_1410);
        foreach (fb[i])
        begin
            @(posedge pclk) transmit_bit_input <= fb[i].tx;
            apb(1'b1, 8'h00, {4'h1, 2'h0, fb[i].n, fb[i].f, 4'h0});
            apb(1'b1, 8'h08, {8'h00, fb[i].m, 6'h00, fb[i].md, 2'h1, 4'h0});
            cyc(10);
            sum = 32'h0000_0000;
            repeat (64)
            begin
                sum = sum + fb_div_int;
                cyc(1);
            end
            chk_w(sum, fb[i].sum, "divide");
        end
        // Chip enable low clears enables and configuration words
        @(posedge pclk) chip_enable_pin <= 1'b0;
        cyc(4);
        chk_w({regulator_enable, osc_enable, synth_enable, vco_enable,
            pa_enable}, 0, "ce off");
        apb(1'b1, 8'h08, 32'hFFFF_FFFF);
        @(posedge pclk) chip_enable_pin <= 1'b1;
        cyc(3);
        wait_ready();
        apb(1'b0, 8'h00, 32'h0000_0000);
        chk_w(rd, 32'h0000_0000, "w0 clr");
        apb(1'b0, 8'h04, 32'h0000_0000);
        chk_w(rd, 32'h0000_1410, "w1 clr");
        apb(1'b0, 8'h08, 32'h0000_0000);
        chk_w(rd, 32'h0000_0000, "w2 clr");
        // Second reset in mid-run
        @(posedge pclk) presetn <= 1'b0;
        cyc(2);
        chk_w({osc_enable, lock_detect, fb_div_int}, 32'h0000_001F, "rst2");
        give_verdict();
    end

    initial
    begin
        #400000;
        abort_run();
    end
endmodule
